// >>> src/dsoh_tx_overhead.sv
// Purpose: overhead insertion port of one transmit channel, own-clock variant
// Assumes: link_clk is the line bit clock; insert pins come from the terminal
// Notes:   overhead bit clock is divided from link_clk and driven out
`include "dsoh_defines.svh"

module dsoh_tx_overhead #(
  parameter int LINE_BITS_PER_OH = `DSOH_LINE_BITS_PER_OH,
  parameter int OH_PER_FRAME     = `DSOH_OH_PER_FRAME
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   link_clk,
  input  wire logic                   line_parity_bit,
  input  wire logic                   oh_insert_enable,
  input  wire logic                   oh_insert_data,
  output logic                        oh_bit_clock,
  output logic                        oh_frame_marker,
  output logic                        oh_line_bit,
  output logic                        oh_line_strobe,
  output logic [`DSOH_POS_W-1:0]      oh_line_pos,
  output logic                        oh_bit,
  output logic                        oh_bit_valid,
  output logic [`DSOH_POS_W-1:0]      oh_bit_pos,
  output logic                        oh_bit_inserted,
  output logic                        frame_begin_indication
);

  localparam int DIV_W = $clog2(LINE_BITS_PER_OH);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINE_BITS_PER_OH - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(LINE_BITS_PER_OH / 2);
  localparam logic [DIV_W-1:0] FALL_AT  = DIV_W'(LINE_BITS_PER_OH / 2 - 1);
  localparam logic [DIV_W-1:0] SAMPLE_AT =
    DIV_W'(LINE_BITS_PER_OH / 2 - 1 + `DSOH_SYNC_STAGES);
  localparam logic [`DSOH_POS_W-1:0] POS_LAST = `DSOH_POS_W'(OH_PER_FRAME - 1);

  // ************************************************************
  // position map
  // ************************************************************
  function automatic dsoh_pkg::dsoh_kind_t kind_of(input logic [`DSOH_POS_W-1:0] pos);
    dsoh_pkg::dsoh_kind_t k;
    k = dsoh_pkg::DSOH_UNMAPPED;
    if (pos > `DSOH_MAP_LAST)
      k = dsoh_pkg::DSOH_UNMAPPED;
    else if (pos[0])
    begin
      if (pos[2:0] == `DSOH_FRAME_ONE_MOD_A || pos[2:0] == `DSOH_FRAME_ONE_MOD_B)
        k = dsoh_pkg::DSOH_FRAMING_ONE;
      else
        k = dsoh_pkg::DSOH_FRAMING_ZERO;
    end
    else if (pos == `DSOH_LINE_PAR_POS_A || pos == `DSOH_LINE_PAR_POS_B)
      k = dsoh_pkg::DSOH_LINE_PARITY;
    else if (pos == `DSOH_MF_ZERO_POS)
      k = dsoh_pkg::DSOH_MF_ZERO;
    else
      k = dsoh_pkg::DSOH_ACCEPTING;
    return k;
  endfunction

  function automatic logic internal_bit(input dsoh_pkg::dsoh_kind_t k, input logic par);
    logic b;
    b = `DSOH_DEFAULT_BIT;
    case (k)
      dsoh_pkg::DSOH_FRAMING_ONE:  b = 1'h1;
      dsoh_pkg::DSOH_FRAMING_ZERO: b = 1'h0;
      dsoh_pkg::DSOH_LINE_PARITY:  b = par;
      dsoh_pkg::DSOH_MF_ZERO:      b = 1'h0;
      default:                     b = `DSOH_DEFAULT_BIT;
    endcase
    return b;
  endfunction

  // ************************************************************
  // link domain reset and pin synchronisers
  // ************************************************************
  logic link_rst_meta_q;
  logic link_rst_q;
  logic ins_en_meta_q;
  logic ins_en_q;
  logic ins_dat_meta_q;
  logic ins_dat_q;

  always_ff @(posedge link_clk)
  begin
    link_rst_meta_q <= rst;
    link_rst_q      <= link_rst_meta_q;
  end

  always_ff @(posedge link_clk)
  begin
    ins_en_meta_q  <= oh_insert_enable;
    ins_en_q       <= ins_en_meta_q;
    ins_dat_meta_q <= oh_insert_data;
    ins_dat_q      <= ins_dat_meta_q;
  end

  // ************************************************************
  // overhead bit clock divider
  // ************************************************************
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic             edge_now;
  logic             fall_now;
  logic             sample_now;

  assign edge_now   = div_q == DIV_LAST;
  assign fall_now   = div_q == FALL_AT;
  assign sample_now = div_q == SAMPLE_AT;
  assign div_d      = edge_now ? '0 : div_q + DIV_W'(1);

  always_ff @(posedge link_clk)
  begin
    if (link_rst_q)
    begin
      div_q        <= '0;
      oh_bit_clock <= 1'h0;
    end
    else
    begin
      div_q        <= div_d;
      oh_bit_clock <= div_d < DIV_HALF;
    end
  end

  // ************************************************************
  // announced position and frame marker
  // ************************************************************
  logic [`DSOH_POS_W-1:0] ann_q;

  // ann_q holds the count of the last rising edge since the marker
  always_ff @(posedge link_clk)
  begin
    if (link_rst_q)
      ann_q <= POS_LAST;
    else if (edge_now)
      ann_q <= (ann_q == POS_LAST) ? '0 : ann_q + `DSOH_POS_W'(1);
  end

  // changes at the falling edge so the terminal sees it settled at edge 0
  always_ff @(posedge link_clk)
  begin
    if (link_rst_q)
      oh_frame_marker <= 1'h0;
    else if (fall_now)
      oh_frame_marker <= ann_q == POS_LAST;
  end

  // ************************************************************
  // insertion capture
  // ************************************************************
  logic hit_q;
  logic val_q;

  always_ff @(posedge link_clk)
  begin
    if (link_rst_q)
    begin
      hit_q <= 1'h0;
      val_q <= 1'h0;
    end
    else if (sample_now)
    begin
      // refusing positions drop the request
      hit_q <= ins_en_q && kind_of(ann_q) == dsoh_pkg::DSOH_ACCEPTING;
      val_q <= ins_dat_q;
    end
    else if (edge_now)
    begin
      hit_q <= 1'h0;
    end
  end

  // ************************************************************
  // overhead bit emission, one period after its announcement
  // ************************************************************
  logic line_ins_q;

  always_ff @(posedge link_clk)
  begin
    if (link_rst_q)
    begin
      oh_line_bit    <= 1'h0;
      oh_line_pos    <= '0;
      oh_line_strobe <= 1'h0;
      line_ins_q     <= 1'h0;
    end
    else
    begin
      oh_line_strobe <= edge_now;
      if (edge_now)
      begin
        oh_line_bit <= hit_q ? val_q : internal_bit(kind_of(ann_q), line_parity_bit);
        oh_line_pos <= ann_q;
        line_ins_q  <= hit_q;
      end
    end
  end

  // ************************************************************
  // hand-off to the system clock
  // ************************************************************
  logic                      xfer_valid;
  logic [`DSOH_POS_W+1:0]    xfer_data;

  dsoh_xfer_sync #(
    .W (`DSOH_POS_W + 2)
  ) u_xfer (
    .src_clk   (link_clk),
    .src_rst   (link_rst_q),
    .src_valid (oh_line_strobe),
    .src_data  ({line_ins_q, oh_line_bit, oh_line_pos}),
    .dst_clk   (clock),
    .dst_rst   (rst),
    .dst_ce    (ce),
    .dst_valid (xfer_valid),
    .dst_data  (xfer_data)
  );

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      oh_bit                 <= 1'h0;
      oh_bit_valid           <= 1'h0;
      oh_bit_pos             <= '0;
      oh_bit_inserted        <= 1'h0;
      frame_begin_indication <= 1'h0;
    end
    else if (ce)
    begin
      oh_bit_valid           <= xfer_valid;
      frame_begin_indication <= xfer_valid && xfer_data[`DSOH_POS_W-1:0] == '0;
      if (xfer_valid)
      begin
        oh_bit_pos      <= xfer_data[`DSOH_POS_W-1:0];
        oh_bit          <= xfer_data[`DSOH_POS_W];
        oh_bit_inserted <= xfer_data[`DSOH_POS_W+1];
      end
    end
  end

endmodule // dsoh_tx_overhead

// >>> src/dsoh_defines.svh
// Purpose: constants of the overhead insertion port of one transmit channel
// Assumes: one overhead bit per 85 line bits, 56 overhead bits per frame
// Notes:   positions are rising-edge counts of the overhead bit clock
//
// Operation
// - counts 0 and 8 are the remote alarm bits and accept external values.
// - odd counts 1 to 37 are framing bits and refuse external values.
// - counts 2, 4 and 6 accept external values.
// - counts 10, 12, 14, 18, 20 and 22 accept external values.
// - counts 16, 24 and 32 are generated internally and refuse external values.
// - counts 26, 28, 30, 34 and 36 accept external values.
// - overhead clock rises one bit period before each overhead bit is processed.
// - frame marker pulses high while the last bit of a frame is processed.
// - insert data sampled at overhead clock fall when enable high, else ignored.
`ifndef DSOH_DEFINES_SVH
`define DSOH_DEFINES_SVH

// ************************************************************
// framing and timing
// ************************************************************
`define DSOH_LINE_BITS_PER_OH 85
`define DSOH_OH_PER_FRAME     56
`define DSOH_SYNC_STAGES      2
`define DSOH_POS_W            6

// ************************************************************
// position map
// ************************************************************
`define DSOH_MAP_LAST         6'h25
`define DSOH_LINE_PAR_POS_A   6'h10
`define DSOH_LINE_PAR_POS_B   6'h18
`define DSOH_MF_ZERO_POS      6'h20
`define DSOH_FRAME_ONE_MOD_A  3'h1
`define DSOH_FRAME_ONE_MOD_B  3'h7
`define DSOH_DEFAULT_BIT      1'h1

`endif

// >>> src/dsoh_pkg.sv
// Purpose: types of the overhead insertion port
// Assumes: nothing
// Notes:   kinds classify each overhead position
package dsoh_pkg;

  typedef enum logic [2:0] {
    DSOH_FRAMING_ONE,
    DSOH_FRAMING_ZERO,
    DSOH_LINE_PARITY,
    DSOH_MF_ZERO,
    DSOH_ACCEPTING,
    DSOH_UNMAPPED
  } dsoh_kind_t;

endpackage

// >>> src/dsoh_xfer_sync.sv
// Purpose: moves one word per event from the link clock into the system clock
// Assumes: events spaced far wider than the handshake round trip
// Notes:   toggle handshake; source word held until the next event
`include "dsoh_defines.svh"

module dsoh_xfer_sync #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  input  wire logic         dst_ce,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);

  logic         tog_q;
  logic [W-1:0] hold_q;
  logic         meta_q;
  logic         sync_q;
  logic         seen_q;

  // ************************************************************
  // source side
  // ************************************************************
  always_ff @(posedge src_clk)
  begin
    if (src_rst)
    begin
      tog_q  <= 1'h0;
      hold_q <= '0;
    end
    else if (src_valid)
    begin
      tog_q  <= ~tog_q;
      hold_q <= src_data;
    end
  end

  // ************************************************************
  // destination side
  // ************************************************************
  always_ff @(posedge dst_clk)
  begin
    if (dst_ce)
    begin
      meta_q <= tog_q;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
    begin
      seen_q    <= 1'h0;
      dst_valid <= 1'h0;
      dst_data  <= '0;
    end
    else if (dst_ce)
    begin
      seen_q    <= sync_q;
      dst_valid <= sync_q != seen_q;
      if (sync_q != seen_q)
      begin
        dst_data <= hold_q;
      end
    end
  end

endmodule // dsoh_xfer_sync

// >>> sim/dsoh_tx_overhead_props.sv
// Purpose: port checks of the overhead insertion block
// Assumes: link side checks run on link_clk
// Notes:   period checks start after the first strobe
`include "dsoh_defines.svh"
module dsoh_tx_overhead_props #(
  parameter int LINE_BITS_PER_OH = 85,
  parameter int OH_PER_FRAME     = 56
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       link_clk,
  input wire logic       line_parity_bit,
  input wire logic       oh_bit_clock,
  input wire logic       oh_frame_marker,
  input wire logic       oh_line_bit,
  input wire logic       oh_line_strobe,
  input wire logic [5:0] oh_line_pos,
  input wire logic       oh_bit_valid,
  input wire logic [5:0] oh_bit_pos,
  input wire logic       oh_bit_inserted,
  input wire logic       frame_begin_indication
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HI = LINE_BITS_PER_OH / 2;
  localparam int LO = LINE_BITS_PER_OH - HI;
  logic [6:0] run_q;
  logic [6:0] gap_q;
  logic       prev_q;
  logic       seen_q;
  logic [5:0] last_q;
  logic       refuse;
  assign refuse = oh_bit_pos[0] || oh_bit_pos > 6'h24 || oh_bit_pos == `DSOH_MF_ZERO_POS
    || oh_bit_pos == `DSOH_LINE_PAR_POS_A || oh_bit_pos == `DSOH_LINE_PAR_POS_B;
  // level run length of the overhead clock
  always_ff @(posedge link_clk)
  begin
    prev_q <= oh_bit_clock;
    run_q  <= (rst || oh_bit_clock != prev_q) ? 7'h01 : run_q + 7'h01;
  end
  always_ff @(posedge link_clk)
    gap_q <= oh_line_strobe ? 7'h00 : gap_q + 7'h01;
  always_ff @(posedge link_clk)
  begin
    if (rst)
      seen_q <= 1'h0;
    else if (oh_line_strobe)
      seen_q <= 1'h1;
  end
  always_ff @(posedge link_clk)
  begin
    if (oh_line_strobe)
      last_q <= oh_line_pos;
  end
  a_clock_high_len: assert property (@(posedge link_clk) disable iff (rst)
    $fell(oh_bit_clock) && seen_q |-> run_q == HI) else $error("clock high time wrong");
  a_clock_low_len: assert property (@(posedge link_clk) disable iff (rst)
    $rose(oh_bit_clock) && seen_q |-> run_q == LO) else $error("clock low time wrong");
  a_strobe_gap: assert property (@(posedge link_clk) disable iff (rst)
    oh_line_strobe && seen_q |-> gap_q == LINE_BITS_PER_OH - 1) else $error("bit period wrong");
  a_pos_step: assert property (@(posedge link_clk) disable iff (rst)
    oh_line_strobe && seen_q |-> oh_line_pos ==
    (last_q == OH_PER_FRAME - 1 ? 6'h00 : last_q + 6'h01)) else $error("position skipped");
  a_marker_last: assert property (@(posedge link_clk) disable iff (rst)
    oh_line_strobe |-> oh_frame_marker == (oh_line_pos == OH_PER_FRAME - 1))
    else $error("frame marker misplaced");
  a_framing_bits: assert property (@(posedge link_clk) disable iff (rst)
    oh_line_strobe && oh_line_pos[0] && oh_line_pos <= `DSOH_MAP_LAST |-> oh_line_bit ==
    (oh_line_pos[2:0] == 3'h1 || oh_line_pos[2:0] == 3'h7)) else $error("framing bit wrong");
  a_mf_zero: assert property (@(posedge link_clk) disable iff (rst)
    oh_line_strobe && oh_line_pos == `DSOH_MF_ZERO_POS |-> !oh_line_bit)
    else $error("multiframe bit wrong");
  a_parity_pass: assert property (@(posedge link_clk) disable iff (rst)
    oh_line_strobe && (oh_line_pos == `DSOH_LINE_PAR_POS_A || oh_line_pos ==
    `DSOH_LINE_PAR_POS_B) |-> oh_line_bit == line_parity_bit) else $error("parity bit wrong");
  a_refused_flag: assert property (@(posedge clock) disable iff (rst)
    oh_bit_valid && refuse |-> !oh_bit_inserted) else $error("refused bit inserted");
  a_frame_begin: assert property (@(posedge clock) disable iff (rst)
    frame_begin_indication == (oh_bit_valid && oh_bit_pos == 6'h00))
    else $error("frame begin wrong");
  cover property (@(posedge clock) oh_bit_valid && oh_bit_inserted);
  cover property (@(posedge clock) frame_begin_indication);
  cover property (@(posedge link_clk) oh_line_strobe && oh_frame_marker);
endmodule // dsoh_tx_overhead_props

bind dsoh_tx_overhead dsoh_tx_overhead_props #(.LINE_BITS_PER_OH(LINE_BITS_PER_OH),
  .OH_PER_FRAME(OH_PER_FRAME)) u_props (.clock, .rst, .link_clk, .line_parity_bit,
  .oh_bit_clock, .oh_frame_marker, .oh_line_bit, .oh_line_strobe, .oh_line_pos,
  .oh_bit_valid, .oh_bit_pos, .oh_bit_inserted, .frame_begin_indication);

// >>> sim/dsoh_terminal_model.sv
// Purpose: terminal side of the overhead insertion port
// Assumes: wanted bits are stable around the frame marker
// Notes:   released data line shows the inverse of its last value
module dsoh_terminal_model (
  input  wire logic        oh_bit_clock,
  input  wire logic        oh_frame_marker,
  input  wire logic [55:0] want_en,
  input  wire logic [55:0] want_val,
  output logic             oh_insert_enable = 1'b0,
  output logic             oh_insert_data   = 1'b0,
  output logic [5:0]       count_q,
  output logic [55:0]      en_log           = '0,
  output logic [55:0]      val_log          = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       synced_q = 1'b0;
  logic [5:0] k;
  logic       en;
  always @(posedge oh_bit_clock)
  begin
    k = oh_frame_marker ? 6'h00 : count_q + 6'h01;
    en = (synced_q || oh_frame_marker) && want_en[k];
    oh_insert_enable <= en;
    oh_insert_data   <= en ? want_val[k] : ~oh_insert_data;
    en_log[k]  <= en;
    val_log[k] <= want_val[k];
    count_q    <= k;
    synced_q   <= synced_q || oh_frame_marker;
  end
endmodule // dsoh_terminal_model

// >>> sim/test_dsoh_tx_overhead.sv
// Purpose: bench of the overhead insertion block
// Assumes: terminal model drives the insert pins
// Notes:   new wanted bits at count 40 take effect next frame
`include "dsoh_defines.svh"
module test_dsoh_tx_overhead;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        line_parity_bit = 1'b0;
  logic [55:0] want_en = '0;
  logic [55:0] want_val = '0;
  logic [55:0] en_log;
  logic [55:0] val_log;
  logic [5:0]  term_pos;
  logic [5:0]  oh_bit_pos;
  logic        oh_insert_enable, oh_insert_data, oh_bit_clock, oh_frame_marker;
  logic        oh_bit, oh_bit_valid, oh_bit_inserted, frame_begin_indication;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  function automatic logic accept(input logic [5:0] p);
    return !p[0] && p <= `DSOH_MAP_LAST && p != `DSOH_MF_ZERO_POS
      && p != `DSOH_LINE_PAR_POS_A && p != `DSOH_LINE_PAR_POS_B;
  endfunction
  function automatic logic exp_bit(input logic [5:0] p);
    if (accept(p) && en_log[p])
      return val_log[p];
    if (p[0] && p <= `DSOH_MAP_LAST)
      return p[2:0] == 3'h1 || p[2:0] == 3'h7;
    if (p == `DSOH_LINE_PAR_POS_A || p == `DSOH_LINE_PAR_POS_B)
      return line_parity_bit;
    return p != `DSOH_MF_ZERO_POS;
  endfunction
  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic complete_run;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  dsoh_tx_overhead uut (.clock, .rst, .ce, .link_clk, .line_parity_bit, .oh_insert_enable,
    .oh_insert_data, .oh_bit_clock, .oh_frame_marker, .oh_line_bit(), .oh_line_strobe(),
    .oh_line_pos(), .oh_bit, .oh_bit_valid, .oh_bit_pos, .oh_bit_inserted,
    .frame_begin_indication);
  dsoh_terminal_model u_term (.oh_bit_clock, .oh_frame_marker, .want_en, .want_val,
    .oh_insert_enable, .oh_insert_data, .count_q(term_pos), .en_log, .val_log);
  initial
    forever #20 clock = ~clock;
  initial
  begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // random clock enable and hang limit
  always @(posedge clock)
  begin
    ce <= ($urandom % 8) != 0;
    cyc++;
    if (cyc > 60000)
    begin
      fail("timeout");
      complete_run();
    end
  end
  always @(posedge clock)
  begin
    #1;
    if (oh_bit_valid === 1'b1)
    begin
      checks += 2;
      if (oh_bit !== exp_bit(oh_bit_pos))
        fail("overhead bit");
      if (oh_bit_inserted !== (accept(oh_bit_pos) && en_log[oh_bit_pos]))
        fail("inserted flag");
    end
  end
  // frames: all enabled, alarm bits zero, then random
  initial
  begin
    void'($urandom(47));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int f = 0; f < 7; f++)
    begin
      while (term_pos !== 6'h28)
        @(posedge clock);
      want_en  <= f == 0 ? '1 : f == 1 ? 56'h00000000000101 : 56'({$urandom, $urandom});
      want_val <= f == 1 ? '0 : 56'({$urandom, $urandom});
      line_parity_bit <= 1'($urandom);
      while (term_pos === 6'h28)
        @(posedge clock);
    end
    // let the last wanted bits go out and be checked
    while (term_pos !== 6'h28)
      @(posedge clock);
    complete_run();
  end
endmodule // test_dsoh_tx_overhead
